// file: test/host_bus_model.sv
/* Behavioural host processor on the parallel bus.
   Assumes strobes are sampled on the rising clock edge. */
`timescale 1ns/1ps
module host_bus_model
    import host_fifo_pkg::*;
(
    input wire logic clk_in, // Clock.
    output logic [host_fifo_pkg::ADDR_W-1:0] addr_out, // Address.
    output logic rd_out, // Read strobe.
    output logic wr_out, // Write strobe.
    output logic [host_fifo_pkg::DATA_W-1:0] wdata_out, // Write data.
    input wire logic [host_fifo_pkg::DATA_W-1:0] rdata_in // Read data.
);
    // Idle bus at time zero.
    initial begin
        rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 32'h0;
    end
    // nothing above the status word is written.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        if (a <= STAT_OFF) begin
            @(negedge clk_in);
            addr_out <= a;
            wdata_out <= d;
            wr_out <= 1'b1;
            @(negedge clk_in);
            wr_out <= 1'b0;
            wdata_out <= ~d;
        end
    endtask
    // The strobe is a pulse, so the answer is taken once it has gone.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(negedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        d = rdata_in;
    endtask
endmodule

// file: test/host_fifo_port_access_properties.sv
/* Port-level assertions for the host FIFO port block.
   Assumes one clock domain; attached by bind from the bench. */
`timescale 1ns/1ps
module host_fifo_port_access_properties
    import host_fifo_pkg::*;
(
    input wire logic ref_clk_in, // Clock.
    input wire logic arst_n_in, // Reset, low.
    input wire logic [host_fifo_pkg::ADDR_W-1:0] host_addr_in, // Address.
    input wire logic host_rd_in, // Read strobe.
    input wire logic host_wr_in, // Write strobe.
    input wire logic [host_fifo_pkg::DATA_W-1:0] host_wdata_in, // Write data.
    input wire logic [host_fifo_pkg::DATA_W-1:0] host_rdata_out, // Read data.
    input wire logic host_rd_ack_out, // Read ack.
    input wire logic host_wr_ack_out, // Write ack.
    input wire logic rx_data_push_in, // Rx push.
    input wire logic tx_data_pop_in, // Tx pop.
    input wire logic tx_word_valid_out, // Tx word valid.
    input wire logic rx_data_full_out, // Rx data full.
    input wire logic tx_data_empty_out, // Tx data empty.
    input wire logic keep_cfg_out // Immune bit.
);
    // ****
    // Helpers
    // ****
    logic srst_wr;
    // Control write with the reset bit; the cycle after it throws strobes away.
    assign srst_wr = host_wr_in && host_addr_in == CTRL_OFF && host_wdata_in[CTRL_SRST_BIT];
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    // ****
    // Assertions
    // ****
    rd_ack_a: assert property (host_rd_in |=> host_rd_ack_out)
        else $error("read strobe got no ack");
    wr_ack_a: assert property (host_wr_in |=> host_wr_ack_out && !host_rd_ack_out)
        else $error("write strobe got no ack");
    wo_zero_a: assert property (
        host_rd_in && host_addr_in[7:6] == 2'b01 |=> host_rdata_out == WORD_ZERO)
        else $error("write-only window read nonzero");
    tx_push_a: assert property (
        host_wr_in && host_addr_in[7:6] == 2'b01 && !$past(srst_wr) |=> ##1 !tx_data_empty_out)
        else $error("tx data write not pushed");
    ro_write_a: assert property (
        host_wr_in && host_addr_in[7:6] == 2'b00 && !rx_data_push_in && !$past(srst_wr)
        |=> ##1 $stable(rx_data_full_out))
        else $error("rx data write changed fifo");
    word_valid_a: assert property (tx_word_valid_out |-> $past(tx_data_pop_in))
        else $error("tx word without pop");
    srst_flush_a: assert property (srst_wr |-> ##[1:4] tx_data_empty_out)
        else $error("soft reset left tx data");
    keep_hold_a: assert property (
        $changed(keep_cfg_out) |-> $past(host_wr_in && host_addr_in == CTRL_OFF))
        else $error("immune bit moved without write");
    cover property (host_rd_in && host_addr_in == RX_STS_POP_OFF);
    cover property (tx_word_valid_out);
    cover property (srst_wr);
endmodule

// file: test/host_fifo_port_access_tb.sv
/* Self-checking bench for the host FIFO port block.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
module host_fifo_port_access_tb;
    import host_fifo_pkg::*;
    localparam logic [31:0] CTRL_DEF = {3'h0, CAP_RST, 3'h0, CAP_RST, 3'h0, CAP_RST, 8'h00};
    logic clk, arst_n, rd, wr, rd_ack, wr_ack, txd_pop, tx_valid, link, keep;
    logic rxd_full, rxs_full, txs_full, txd_empty;
    logic [2:0] push_v;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, mac_d, tx_word;
    int fails, n_checks;
    host_bus_model u_host (.clk_in(clk), .addr_out(addr), .rd_out(rd), .wr_out(wr),
        .wdata_out(wdata), .rdata_in(rdata));
    host_fifo_port_access u_host_fifo_port_access (.ref_clk_in(clk), .arst_n_in(arst_n),
        .host_addr_in(addr), .host_rd_in(rd), .host_wr_in(wr), .host_wdata_in(wdata),
        .host_rdata_out(rdata), .host_rd_ack_out(rd_ack), .host_wr_ack_out(wr_ack),
        .rx_data_push_in(push_v[0]), .rx_data_in(mac_d), .rx_sts_push_in(push_v[1]),
        .rx_sts_in(mac_d), .tx_sts_push_in(push_v[2]), .tx_sts_in(mac_d),
        .tx_data_pop_in(txd_pop), .tx_word_out(tx_word), .tx_word_valid_out(tx_valid),
        .rx_data_full_out(rxd_full), .rx_sts_full_out(rxs_full), .tx_sts_full_out(txs_full),
        .tx_data_empty_out(txd_empty), .link_up_in(link), .keep_cfg_out(keep));
    // ****
    // Helpers
    // ****
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        u_host.rd(a, d);
        check(d, e);
    endtask
    // MAC side pushes one word into fifo k (0 rx data, 1 rx status, 2 tx status).
    task automatic push(input int k, input logic [31:0] d);
        @(negedge clk);
        mac_d <= d;
        push_v <= 3'(1 << k);
        @(negedge clk);
        push_v <= 3'h0;
    endtask
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_sts(input int k, input logic [7:0] pop, input int lsb);
        push(k, 32'ha5a5_0001);
        push(k, 32'h5a5a_0002);
        rc(pop + 8'h04, 32'ha5a5_0001);
        rc(pop + 8'h04, 32'ha5a5_0001);
        u_host.wr(pop, 32'hffff_ffff);
        rc(STAT_OFF, 32'h2 << lsb);
        rc(pop, 32'ha5a5_0001);
        rc(STAT_OFF, 32'h1 << lsb);
        rc(pop, 32'h5a5a_0002);
        $display("status fifo test done");
    endtask
    task automatic t_rxd();
        logic [31:0] d;
        for (int i = 0; i <= FIFO_DEPTH; i++) begin
            push(0, 32'hd000_0000 + i);
        end
        u_host.wr(8'h00, 32'h0);
        rc(STAT_OFF, 32'((FIFO_DEPTH << STAT_RXD_CNT_LSB) | 8));
        rc(STAT_OFF, 32'(FIFO_DEPTH << STAT_RXD_CNT_LSB));
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            rc(8'(i * 4), 32'hd000_0000 + i);
        end
        u_host.rd(8'h3c, d);
        rc(STAT_OFF, 32'h2);
        rc(STAT_OFF, 32'h0);
        $display("rx data test done");
    endtask
    task automatic t_txd();
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            u_host.wr(8'h40 + 8'(i * 4), 32'hc000_0000 + i);
        end
        rc(8'h44, WORD_ZERO);
        u_host.wr(8'h7c, 32'h1);
        rc(STAT_OFF, 32'h1);
        u_host.wr(STAT_OFF, 32'h0);
        rc(STAT_OFF, 32'h1);
        u_host.wr(STAT_OFF, 32'h1);
        rc(STAT_OFF, 32'h0);
        for (int i = 0; i < FIFO_DEPTH; i++) begin
            @(negedge clk);
            txd_pop <= 1'b1;
            @(negedge clk);
            txd_pop <= 1'b0;
            check({31'h0, tx_valid}, 32'h1);
            check(tx_word, 32'hc000_0000 + i);
        end
        @(negedge clk);
        check({31'h0, txd_empty}, 32'h1);
        $display("tx data test done");
    endtask
    task automatic t_link();
        link <= 1'b1;
        repeat (4) @(negedge clk);
        rc(STAT_OFF, 32'h0);
        rc(STAT_OFF, 32'h4);
        link <= 1'b0;
        repeat (4) @(negedge clk);
        link <= 1'b1;
        repeat (4) @(negedge clk);
        rc(STAT_OFF, 32'h0);
        rc(STAT_OFF, 32'h4);
        $display("link latch test done");
    endtask
    task automatic t_soft();
        u_host.wr(CTRL_OFF, 32'h1010_0402);
        rc(CTRL_OFF, 32'h1010_0402);
        for (int i = 0; i < 5; i++) begin
            push(0, 32'(i));
        end
        @(negedge clk);
        check({31'h0, rxd_full}, 32'h1);
        rc(STAT_OFF, 32'h0000_040c);
        u_host.wr(CTRL_OFF, 32'h1010_0403);
        repeat (2) @(negedge clk);
        rc(CTRL_OFF, {CTRL_DEF[31:2], 2'b10});
        rc(STAT_OFF, 32'h0);
        check({31'h0, rxd_full}, 32'h0);
        arst_n <= 1'b0;
        @(negedge clk);
        arst_n <= 1'b1;
        check({31'h0, keep}, 32'h0);
        $display("soft reset test done");
    endtask
    // Free-running 50 MHz clock.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Main sequence: reset held for 20 cycles, then each scenario in turn.
    initial begin
        arst_n = 1'b0;
        push_v = 3'h0;
        mac_d = 32'h0;
        txd_pop = 1'b0;
        link = 1'b0;
        repeat (20) @(negedge clk);
        arst_n <= 1'b1;
        rc(CTRL_OFF, CTRL_DEF);
        check({31'h0, txd_empty}, 32'h1);
        t_sts(1, RX_STS_POP_OFF, STAT_RXS_CNT_LSB);
        t_sts(2, TX_STS_POP_OFF, STAT_TXS_CNT_LSB);
        t_rxd();
        t_txd();
        t_link();
        t_soft();
        end_of_test();
    end
    // Watchdog: the run needs well under a thousand cycles.
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule
bind host_fifo_port_access host_fifo_port_access_properties u_props (
    .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .host_addr_in(host_addr_in),
    .host_rd_in(host_rd_in), .host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in),
    .host_rdata_out(host_rdata_out), .host_rd_ack_out(host_rd_ack_out),
    .host_wr_ack_out(host_wr_ack_out), .rx_data_push_in(rx_data_push_in),
    .tx_data_pop_in(tx_data_pop_in), .tx_word_valid_out(tx_word_valid_out),
    .rx_data_full_out(rx_data_full_out), .tx_data_empty_out(tx_data_empty_out),
    .keep_cfg_out(keep_cfg_out));

// file: verilog/fifo_store.sv
/*
 * Flip-flop FIFO with a run-time capacity and a synchronous clear.
 * Assumes push and pop on the same clock; push when full
 * and pop when empty are ignored.
 */
`timescale 1ns/1ps
module fifo_store #(
    parameter int W = 32,
    parameter int D = 16
) (
    input wire logic ref_clk_in, // System clock.
    input wire logic arst_n_in, // Asynchronous reset, active low.
    input wire logic clr_in, // Synchronous flush.
    input wire logic [4:0] cap_in, // Usable entries, 1 to D.
    input wire logic push_in, // Write one word.
    input wire logic [W-1:0] push_data_in, // Word to write.
    input wire logic pop_in, // Remove the head word.
    output logic [W-1:0] head_out, // Head word, valid when not empty.
    output logic [4:0] count_out, // Words held.
    output logic full_out, // Count has reached capacity.
    output logic empty_out // No words held.
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (D < 2 || D > 16 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("fifo_store depth must be a power of two from 2 to 16");
    end

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [4:0] count;
    } fifo_state_t;

    fifo_state_t s_r;
    fifo_state_t s_nxt;
    logic [4:0] cap_eff;
    logic do_push;
    logic do_pop;

    // A capacity of zero or above the depth is clamped so the FIFO always works.
    assign cap_eff = (cap_in == 5'h00) ? 5'h01 : ((cap_in > 5'(D)) ? 5'(D) : cap_in);
    assign full_out = (s_r.count >= cap_eff);
    assign empty_out = (s_r.count == 5'h00);
    assign count_out = s_r.count;
    assign head_out = s_r.mem[s_r.rd_ptr];
    assign do_push = push_in && !full_out;
    assign do_pop = pop_in && !empty_out;

    // Pointer and count update; a clear drops all contents.
    always_comb begin
        s_nxt = s_r;
        if (clr_in) begin
            s_nxt.wr_ptr = '0;
            s_nxt.rd_ptr = '0;
            s_nxt.count = 5'h00;
        end else begin
            if (do_push) begin
                s_nxt.mem[s_r.wr_ptr] = push_data_in;
                s_nxt.wr_ptr = s_r.wr_ptr + 1'b1;
            end
            if (do_pop) begin
                s_nxt.rd_ptr = s_r.rd_ptr + 1'b1;
            end
            s_nxt.count = s_r.count + 5'(do_push) - 5'(do_pop);
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// file: verilog/host_fifo_pkg.sv
/*
 * Constants for the host FIFO port block:
 * word map, field positions,
 * reset values and sizing.
 * Assumes a 32-bit host data path with word-aligned byte addresses.
 */
package host_fifo_pkg;

    // ************************************************************
    // Sizing
    // ************************************************************
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int CAP_W = 5;
    localparam int ADDR_W = 8;

    // ************************************************************
    // Host word map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ALIAS_MASK = 8'hc0;
    localparam logic [7:0] RX_DATA_BASE = 8'h00;
    localparam logic [7:0] TX_DATA_BASE = 8'h40;
    localparam logic [7:0] RX_STS_POP_OFF = 8'h80;
    localparam logic [7:0] RX_STS_PEEK_OFF = 8'h84;
    localparam logic [7:0] TX_STS_POP_OFF = 8'h88;
    localparam logic [7:0] TX_STS_PEEK_OFF = 8'h8c;
    localparam logic [7:0] CTRL_OFF = 8'h90;
    localparam logic [7:0] STAT_OFF = 8'h94;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_SRST_BIT = 0;
    localparam int CTRL_KEEP_BIT = 1;
    localparam int CTRL_RXD_CAP_LSB = 8;
    localparam int CTRL_TXD_CAP_LSB = 16;
    localparam int CTRL_RXS_CAP_LSB = 24;
    localparam int STAT_TXOVR_BIT = 0;
    localparam int STAT_RXUND_BIT = 1;
    localparam int STAT_LINK_BIT = 2;
    localparam int STAT_RXOVF_BIT = 3;
    localparam int STAT_RXD_CNT_LSB = 8;
    localparam int STAT_RXS_CNT_LSB = 16;
    localparam int STAT_TXS_CNT_LSB = 24;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [4:0] CAP_RST = 5'h10;
    localparam logic KEEP_RST = 1'b0;
    localparam logic LINK_LAT_RST = 1'b0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// file: verilog/host_fifo_port_access.sv
/*
 * Host access to the four data-path FIFOs
 * plus a control word and a status word
 * showing each access attribute.
 * Assumes MAC and host share ref_clk_in;
 * only link_up_in is synchronised.
 */
// Notes on behaviour
// R1: Writes to read-only locations are ignored.
// R2: Reads of write-only locations return zero.
// R3: Writing one clears; writing zero keeps.
// R4: Clear-on-read bits clear when read.
// R5: Latched bits hold until read, then clear.
// R6: Soft-reset-immune bits survive software reset.
// R7: Host writes zero to reserved bits.
// R8: Host never writes reserved locations.
// R9: Any reset loads default register values.
// R10: FIFO capacities set by configuration word. The transmit status capacity is fixed at the full depth instead.
// R11: Receive FIFOs are read-only to host.
// R12: Receive status pop read removes head.
// R13: Receive status peek leaves FIFO unchanged.
// R14: Receive data reads pop, sixteen aliases.
// R15: Transmit status pop read removes head.
// R16: Transmit status peek leaves FIFO unchanged.
// R17: Transmit data writes push, sixteen aliases.
// R18: Software reset request bit clears itself.
`timescale 1ns/1ps
module host_fifo_port_access
    import host_fifo_pkg::*;
#(
    parameter int DEPTH = host_fifo_pkg::FIFO_DEPTH
) (
    input wire logic ref_clk_in, // 50 MHz clock.
    input wire logic arst_n_in, // System reset, low.
    input wire logic [host_fifo_pkg::ADDR_W-1:0] host_addr_in, // Byte address.
    input wire logic host_rd_in, // Read strobe.
    input wire logic host_wr_in, // Write strobe.
    input wire logic [host_fifo_pkg::DATA_W-1:0] host_wdata_in, // Write data.
    output logic [host_fifo_pkg::DATA_W-1:0] host_rdata_out, // Read data.
    output logic host_rd_ack_out, // Read done pulse.
    output logic host_wr_ack_out, // Write done pulse.
    input wire logic rx_data_push_in, // MAC writes rx word.
    input wire logic [host_fifo_pkg::DATA_W-1:0] rx_data_in, // Rx data word.
    input wire logic rx_sts_push_in, // MAC writes rx status.
    input wire logic [host_fifo_pkg::DATA_W-1:0] rx_sts_in, // Rx status word.
    input wire logic tx_sts_push_in, // MAC writes tx status.
    input wire logic [host_fifo_pkg::DATA_W-1:0] tx_sts_in, // Tx status word.
    input wire logic tx_data_pop_in, // MAC takes tx word.
    output logic [host_fifo_pkg::DATA_W-1:0] tx_word_out, // Tx word taken.
    output logic tx_word_valid_out, // Tx word valid pulse.
    output logic rx_data_full_out, // Rx data full.
    output logic rx_sts_full_out, // Rx status full.
    output logic tx_sts_full_out, // Tx status full.
    output logic tx_data_empty_out, // Tx data empty.
    input wire logic link_up_in, // Link pin, async.
    output logic keep_cfg_out // Reset-immune bit.
);
    import host_fifo_pkg::*;

    // ************************************************************
    // Elaboration check
    // ************************************************************
    if (DEPTH < 2 || DEPTH > FIFO_DEPTH || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two from 2 to 16");
    end

    typedef struct packed {
        logic [1:0] link_sync;
        logic srst_pend;
        logic keep;
        logic [4:0] rxd_cap;
        logic [4:0] txd_cap;
        logic [4:0] rxs_cap;
        logic tx_ovr;
        logic rx_und;
        logic link_lat;
        logic rx_ovf;
        logic [31:0] rdata;
        logic rd_ack;
        logic wr_ack;
        logic [31:0] tx_word;
        logic tx_word_valid;
        logic rxd_full;
        logic rxs_full;
        logic txs_full;
        logic txd_empty;
    } port_state_t;

    port_state_t s_r;
    port_state_t s_nxt;

    // ************************************************************
    // Address decode helpers
    // ************************************************************
    function automatic logic in_window(input logic [7:0] addr, input logic [7:0] base);
        in_window = ((addr & ALIAS_MASK) == base);
    endfunction

    function automatic logic [31:0] put_field(input logic [4:0] val, input int lsb);
        put_field = 32'(val) << lsb;
    endfunction

    logic rd_rxd;
    logic rd_rxs_pop;
    logic rd_txs_pop;
    logic wr_txd;
    logic rd_stat;
    logic wr_stat;
    logic wr_ctrl;

    // Strobes that move FIFO contents, then the status and control strobes; peeks are decoded separately below.
    // R14: any of the sixteen receive data aliases pops.
    assign rd_rxd = host_rd_in && in_window(host_addr_in, RX_DATA_BASE);
    // R12: the popping receive status port removes the head.
    assign rd_rxs_pop = host_rd_in && (host_addr_in == RX_STS_POP_OFF);
    // R15: the popping transmit status port removes the head.
    assign rd_txs_pop = host_rd_in && (host_addr_in == TX_STS_POP_OFF);
    // R17: any of the sixteen transmit data aliases pushes.
    assign wr_txd = host_wr_in && in_window(host_addr_in, TX_DATA_BASE);
    assign rd_stat = host_rd_in && (host_addr_in == STAT_OFF);
    assign wr_stat = host_wr_in && (host_addr_in == STAT_OFF);
    assign wr_ctrl = host_wr_in && (host_addr_in == CTRL_OFF);

    // ************************************************************
    // FIFO instances
    // ************************************************************
    logic [31:0] rxd_head;
    logic [31:0] rxs_head;
    logic [31:0] txs_head;
    logic [31:0] txd_head;
    logic [4:0] rxd_cnt;
    logic [4:0] rxs_cnt;
    logic [4:0] txs_cnt;
    logic rxd_full;
    logic rxs_full;
    logic txs_full;
    logic txd_full;
    logic rxd_empty;
    logic rxs_empty;
    logic txs_empty;
    logic txd_empty;
    logic soft_clr;

    // A software reset flushes every FIFO in the same cycle as the registers.
    assign soft_clr = s_r.srst_pend;

    // R10: receive data capacity comes from the control word.
    fifo_store #(.W(DATA_W), .D(DEPTH)) u_rxd (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clr_in(soft_clr),
        .cap_in(s_r.rxd_cap), .push_in(rx_data_push_in), .push_data_in(rx_data_in),
        .pop_in(rd_rxd && !soft_clr), .head_out(rxd_head), .count_out(rxd_cnt),
        .full_out(rxd_full), .empty_out(rxd_empty)
    );
    fifo_store #(.W(DATA_W), .D(DEPTH)) u_rxs (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clr_in(soft_clr),
        .cap_in(s_r.rxs_cap), .push_in(rx_sts_push_in), .push_data_in(rx_sts_in),
        .pop_in(rd_rxs_pop && !soft_clr), .head_out(rxs_head), .count_out(rxs_cnt),
        .full_out(rxs_full), .empty_out(rxs_empty)
    );
    // Transmit status has no host-set capacity, so it uses the full depth.
    fifo_store #(.W(DATA_W), .D(DEPTH)) u_txs (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clr_in(soft_clr),
        .cap_in(5'(DEPTH)), .push_in(tx_sts_push_in), .push_data_in(tx_sts_in),
        .pop_in(rd_txs_pop && !soft_clr), .head_out(txs_head), .count_out(txs_cnt),
        .full_out(txs_full), .empty_out(txs_empty)
    );
    fifo_store #(.W(DATA_W), .D(DEPTH)) u_txd (
        .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .clr_in(soft_clr),
        .cap_in(s_r.txd_cap), .push_in(wr_txd && !soft_clr), .push_data_in(host_wdata_in),
        .pop_in(tx_data_pop_in), .head_out(txd_head), .count_out(),
        .full_out(txd_full), .empty_out(txd_empty)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    // Host access, attribute bits and the transmit drain all settle here.
    always_comb begin
        s_nxt = s_r;
        s_nxt.link_sync = {s_r.link_sync[0], link_up_in};
        s_nxt.rd_ack = host_rd_in;
        s_nxt.wr_ack = host_wr_in;
        s_nxt.rdata = WORD_ZERO;
        s_nxt.rxd_full = rxd_full;
        s_nxt.rxs_full = rxs_full;
        s_nxt.txs_full = txs_full;
        s_nxt.txd_empty = txd_empty;
        s_nxt.tx_word_valid = tx_data_pop_in && !txd_empty;
        if (tx_data_pop_in && !txd_empty) begin
            s_nxt.tx_word = txd_head;
        end

        // Read data mux; unmapped and reserved words read as zero.
        if (in_window(host_addr_in, RX_DATA_BASE)) begin
            s_nxt.rdata = rxd_head;
        end else if (in_window(host_addr_in, TX_DATA_BASE)) begin
            // R2: transmit data is write-only and reads zero.
            s_nxt.rdata = WORD_ZERO;
        end else if (host_addr_in == RX_STS_POP_OFF || host_addr_in == RX_STS_PEEK_OFF) begin
            // R13: peek shares the head word but never pops.
            s_nxt.rdata = rxs_head;
        end else if (host_addr_in == TX_STS_POP_OFF || host_addr_in == TX_STS_PEEK_OFF) begin
            // R16: peek shares the head word but never pops.
            s_nxt.rdata = txs_head;
        end else if (host_addr_in == CTRL_OFF) begin
            s_nxt.rdata = put_field(s_r.rxd_cap, CTRL_RXD_CAP_LSB)
                        | put_field(s_r.txd_cap, CTRL_TXD_CAP_LSB)
                        | put_field(s_r.rxs_cap, CTRL_RXS_CAP_LSB)
                        | (32'(s_r.keep) << CTRL_KEEP_BIT)
                        | (32'(s_r.srst_pend) << CTRL_SRST_BIT);
        end else if (host_addr_in == STAT_OFF) begin
            s_nxt.rdata = put_field(rxd_cnt, STAT_RXD_CNT_LSB)
                        | put_field(rxs_cnt, STAT_RXS_CNT_LSB)
                        | put_field(txs_cnt, STAT_TXS_CNT_LSB)
                        | (32'(s_r.tx_ovr) << STAT_TXOVR_BIT)
                        | (32'(s_r.rx_und) << STAT_RXUND_BIT)
                        | (32'(s_r.link_lat) << STAT_LINK_BIT)
                        | (32'(s_r.rx_ovf) << STAT_RXOVF_BIT);
        end
        if (!host_rd_in) begin
            s_nxt.rdata = s_r.rdata;
        end

        // Control word here; besides it only the status word
        // and the transmit data window take write data.
        // R1: only writable fields are taken.
        // R11: receive ports ignore writes.
        if (wr_ctrl) begin
            s_nxt.rxd_cap = host_wdata_in[CTRL_RXD_CAP_LSB +: CAP_W];
            s_nxt.txd_cap = host_wdata_in[CTRL_TXD_CAP_LSB +: CAP_W];
            s_nxt.rxs_cap = host_wdata_in[CTRL_RXS_CAP_LSB +: CAP_W];
            s_nxt.keep = host_wdata_in[CTRL_KEEP_BIT];
            s_nxt.srst_pend = host_wdata_in[CTRL_SRST_BIT];
        end

        // R4: read clears the overflow flag.
        // R5: latched bits clear or reload on read.
        if (rd_stat) begin
            s_nxt.rx_ovf = 1'b0;
            s_nxt.rx_und = 1'b0;
            s_nxt.link_lat = s_r.link_sync[1];
        end
        // R3: one clears, zero keeps.
        if (wr_stat && host_wdata_in[STAT_TXOVR_BIT]) begin
            s_nxt.tx_ovr = 1'b0;
        end

        // Events come last so a set in the clearing cycle is not lost.
        if (wr_txd && txd_full) begin
            s_nxt.tx_ovr = 1'b1;
        end
        if (rd_rxd && rxd_empty) begin
            s_nxt.rx_und = 1'b1;
        end
        if (rx_data_push_in && rxd_full) begin
            s_nxt.rx_ovf = 1'b1;
        end
        // Latch low: a dropped link holds zero until the status word is read.
        if (!s_r.link_sync[1]) begin
            s_nxt.link_lat = 1'b0;
        end

        // R9: software reset restores register defaults.
        // R6: the reset-immune bit and the synchroniser are kept.
        // R18: the request bit clears itself here.
        if (s_r.srst_pend) begin
            s_nxt = '0;
            s_nxt.link_sync = {s_r.link_sync[0], link_up_in};
            s_nxt.keep = s_r.keep;
            s_nxt.rxd_cap = CAP_RST;
            s_nxt.txd_cap = CAP_RST;
            s_nxt.rxs_cap = CAP_RST;
            s_nxt.link_lat = LINK_LAT_RST;
            s_nxt.rd_ack = host_rd_in;
            s_nxt.wr_ack = host_wr_in;
            s_nxt.txd_empty = 1'b1;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // R9: system reset loads every default, including the immune bit.
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_r <= '0;
            s_r.keep <= KEEP_RST;
            s_r.rxd_cap <= CAP_RST;
            s_r.txd_cap <= CAP_RST;
            s_r.rxs_cap <= CAP_RST;
            s_r.link_lat <= LINK_LAT_RST;
            s_r.txd_empty <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Every output is a bare flop of the state word.
    assign host_rdata_out = s_r.rdata;
    assign host_rd_ack_out = s_r.rd_ack;
    assign host_wr_ack_out = s_r.wr_ack;
    assign tx_word_out = s_r.tx_word;
    assign tx_word_valid_out = s_r.tx_word_valid;
    assign rx_data_full_out = s_r.rxd_full;
    assign rx_sts_full_out = s_r.rxs_full;
    assign tx_sts_full_out = s_r.txs_full;
    assign tx_data_empty_out = s_r.txd_empty;
    assign keep_cfg_out = s_r.keep;

endmodule
